/* design/pse_datapath.sv */
// Notes on behaviour
// - low dword multiply keeps low 32 bits
// - wide multiply gives two signed 64-bit products
// - double dot product, two pairs, broadcast
// - single dot product, four pairs, broadcast
// - streaming load fetches whole aligned line
// - later hits served from streaming buffer
// - immediate blends copy selected source elements
// - variable blends select by mask sign
// - per-lane min and max, four types
// - packed rounding to integral float values
// - scalar rounding touches lowest element only
// - selectable rounding mode, inexact suppression
// - single extraction to register or memory
// - single insertion from memory or register
// - single insertion zeroes masked elements
// - integer insertion of byte, dword, qword
// - integer extraction of byte to qword
// - only 128-bit vector register forms
module pse_datapath import pse_pkg::*; (
   input  wire logic               clk,        // core clock
   input  wire logic               nrst,       // async reset, active low
   input  wire pse_req_t           req,        // operation and operands
   input  wire logic               req_valid,  // request present
   output      logic               req_ready,  // idle, request taken when valid
   input  wire logic [1:0]         rc_mode,    // default rounding mode
   output      logic               mem_req,    // line fetch request
   output      logic [ADDR_W-1:0]  mem_addr,   // aligned line address
   input  wire logic               mem_rvalid, // line data returned
   input  wire logic [LINE_W-1:0]  mem_rdata,  // whole line
   output      pse_rsp_t           rsp,        // result
   output      logic               rsp_valid   // result pulse
);
   pse_state_t state_ff, nxt_state;
   pse_rsp_t rsp_ff, nxt_rsp;
   logic rsp_valid_ff, nxt_rsp_valid;
   logic [ADDR_W-1:0] ld_addr_ff, nxt_ld_addr;
   logic [LINE_W-1:0] sbuf_ff [SBUF_N];
   logic [ADDR_W-LINE_LSB-1:0] stag_ff [SBUF_N];
   logic [SBUF_N-1:0] svld_ff, nxt_svld;
   logic victim_ff, nxt_victim;
   logic fill;
   logic take;
   logic hit;
   logic hit_idx;
   logic [VEC_W-1:0] alu_vec;
   logic [63:0] alu_gpr;
   logic alu_inx;

   function automatic logic [63:0] f_mul(input logic [63:0] x,
                                         input logic [63:0] y);
      logic [105:0] m;
      logic [12:0] e;
      logic s;
      s = x[63] ^ y[63];
      if (x[62:52] == 11'h0 || y[62:52] == 11'h0) return {s, 63'h0};
      m = {1'b1, x[51:0]} * {1'b1, y[51:0]};
      e = {2'b0, x[62:52]} + {2'b0, y[62:52]} - {2'b0, DBL_BIAS};
      if (m[105]) begin
         m = m >> 1;
         e = e + 13'h1;
      end
      if (e[12] || e == 13'h0) return {s, 63'h0};
      if (e >= {2'b0, DBL_MAX_EXP}) return {s, DBL_MAX_EXP, 52'h0};
      return {s, e[10:0], m[103:52]};
   endfunction

   function automatic logic [63:0] f_add(input logic [63:0] x,
                                         input logic [63:0] y);
      logic [63:0] p, q;
      logic [10:0] d;
      logic [56:0] mp, mq, ms;
      logic [11:0] e;
      if (x[62:0] < y[62:0]) begin
         p = y;
         q = x;
      end else begin
         p = x;
         q = y;
      end
      if (q[62:52] == 11'h0) return (p[62:52] == 11'h0) ? 64'h0 : p;
      d = p[62:52] - q[62:52];
      mp = {2'b01, p[51:0], 3'b0};
      mq = (d > 11'd56) ? 57'h0 : ({2'b01, q[51:0], 3'b0} >> d);
      ms = (p[63] == q[63]) ? mp + mq : mp - mq;
      if (ms == 57'h0) return 64'h0;
      e = {1'b0, p[62:52]};
      if (ms[56]) begin
         ms = ms >> 1;
         e = e + 12'h1;
      end
      for (int i = 0; i < 56; i++) begin
         if (!ms[55] && e != 12'h0) begin
            ms = ms << 1;
            e = e - 12'h1;
         end
      end
      if (e == 12'h0) return {p[63], 63'h0};
      if (e >= {1'b0, DBL_MAX_EXP}) return {p[63], DBL_MAX_EXP, 52'h0};
      return {p[63], e[10:0], ms[54:3]};
   endfunction

   function automatic logic [63:0] s2d(input logic [31:0] x);
      if (x[30:23] == 8'h0) return {x[31], 63'h0};
      if (x[30:23] == 8'hff) return {x[31], DBL_MAX_EXP, x[22:0], 29'h0};
      return {x[31], {3'b0, x[30:23]} + SGL_REBIAS, x[22:0], 29'h0};
   endfunction

   function automatic logic [31:0] d2s(input logic [63:0] x);
      logic [10:0] e;
      e = x[62:52] - SGL_REBIAS;
      if (x[62:52] <= SGL_REBIAS) return {x[63], 31'h0};
      if (x[62:52] >= SGL_MAX_IN_DBL) return {x[63], 8'hff, x[51:29]};
      return {x[63], e[7:0], x[51:29]};
   endfunction

   // {inexact, value}: round a double to an integral double
   function automatic logic [64:0] f_rint(input logic [63:0] x,
                                          input logic [1:0] rm);
      logic [10:0] sh;
      logic [62:0] ulp, rem, mag, half;
      logic inc;
      if (x[62:52] >= DBL_INT_EXP || x[62:52] == 11'h0) return {1'b0, x};
      if (x[62:52] < DBL_BIAS) begin
         case (rm)
            RM_NEAR: inc = (x[62:52] == DBL_BIAS - 11'h1) && x[51:0] != 0;
            RM_DOWN: inc = x[63];
            RM_UP:   inc = !x[63];
            default: inc = 1'b0;
         endcase
         return {1'b1, x[63], inc ? {DBL_BIAS, 52'h0} : 63'h0};
      end
      sh = DBL_INT_EXP - x[62:52];
      ulp = 63'h1 << sh;
      half = ulp >> 1;
      rem = x[62:0] & (ulp - 63'h1);
      mag = x[62:0] & ~(ulp - 63'h1);
      case (rm)
         RM_NEAR: inc = rem > half || (rem == half && (x[62:0] & ulp) != 0);
         RM_DOWN: inc = x[63] && rem != 0;
         RM_UP:   inc = !x[63] && rem != 0;
         default: inc = 1'b0;
      endcase
      if (inc) mag = mag + ulp;
      return {rem != 63'h0, x[63], mag};
   endfunction

   // 128-bit forms only
   // operand-only operations
   always_comb begin
      logic [1:0] rm;
      logic [64:0] rd;
      logic [63:0] prod [4];
      logic [63:0] sum;
      logic [31:0] ins;
      rm = req.imm[IMM_RC_SRC] ? rc_mode : req.imm[1:0];
      rd = '0;
      sum = '0;
      ins = '0;
      for (int i = 0; i < 4; i++) prod[i] = '0;
      alu_vec = req.dst;
      alu_gpr = '0;
      alu_inx = 1'b0;
      case (req.op)
         OP_MUL_DWORD_LOW:
            for (int i = 0; i < 4; i++)
               alu_vec[i*32 +: 32] = 32'(signed'(req.dst[i*32 +: 32]) *
                                         signed'(req.src[i*32 +: 32]));
         OP_MUL_DWORD_WIDE:
            for (int i = 0; i < 2; i++)
               alu_vec[i*64 +: 64] =
                  64'(signed'({{32{req.dst[i*64+31]}}, req.dst[i*64 +: 32]}) *
                      signed'({{32{req.src[i*64+31]}}, req.src[i*64 +: 32]}));
         OP_DOT_DOUBLE: begin
            for (int i = 0; i < 2; i++)
               if (req.imm[4+i])
                  prod[i] = f_mul(req.dst[i*64 +: 64], req.src[i*64 +: 64]);
            sum = f_add(prod[0], prod[1]);
            for (int i = 0; i < 2; i++)
               alu_vec[i*64 +: 64] = req.imm[i] ? sum : 64'h0;
         end
         OP_DOT_SINGLE: begin
            for (int i = 0; i < 4; i++)
               if (req.imm[4+i])
                  prod[i] = f_mul(s2d(req.dst[i*32 +: 32]),
                                  s2d(req.src[i*32 +: 32]));
            sum = f_add(f_add(prod[0], prod[1]), f_add(prod[2], prod[3]));
            for (int i = 0; i < 4; i++)
               alu_vec[i*32 +: 32] = req.imm[i] ? d2s(sum) : 32'h0;
         end
         OP_BLEND_DOUBLE_IMM:
            for (int i = 0; i < 2; i++)
               if (req.imm[i]) alu_vec[i*64 +: 64] = req.src[i*64 +: 64];
         OP_BLEND_SINGLE_IMM:
            for (int i = 0; i < 4; i++)
               if (req.imm[i]) alu_vec[i*32 +: 32] = req.src[i*32 +: 32];
         OP_BLEND_WORD_IMM:
            for (int i = 0; i < 8; i++)
               if (req.imm[i]) alu_vec[i*16 +: 16] = req.src[i*16 +: 16];
         OP_BLEND_DOUBLE_VAR:
            for (int i = 0; i < 2; i++)
               if (req.mask[i*64+63])
                  alu_vec[i*64 +: 64] = req.src[i*64 +: 64];
         OP_BLEND_SINGLE_VAR:
            for (int i = 0; i < 4; i++)
               if (req.mask[i*32+31])
                  alu_vec[i*32 +: 32] = req.src[i*32 +: 32];
         OP_BLEND_BYTE_VAR:
            for (int i = 0; i < 16; i++)
               if (req.mask[i*8+7]) alu_vec[i*8 +: 8] = req.src[i*8 +: 8];
         OP_MIN_UWORD, OP_MAX_UWORD:
            for (int i = 0; i < 8; i++)
               if ((req.src[i*16 +: 16] < req.dst[i*16 +: 16]) ==
                   (req.op == OP_MIN_UWORD))
                  alu_vec[i*16 +: 16] = req.src[i*16 +: 16];
         OP_MIN_UDWORD, OP_MAX_UDWORD:
            for (int i = 0; i < 4; i++)
               if ((req.src[i*32 +: 32] < req.dst[i*32 +: 32]) ==
                   (req.op == OP_MIN_UDWORD))
                  alu_vec[i*32 +: 32] = req.src[i*32 +: 32];
         OP_MIN_SBYTE, OP_MAX_SBYTE:
            for (int i = 0; i < 16; i++)
               if ((signed'(req.src[i*8 +: 8]) < signed'(req.dst[i*8 +: 8]))
                   == (req.op == OP_MIN_SBYTE))
                  alu_vec[i*8 +: 8] = req.src[i*8 +: 8];
         OP_MIN_SDWORD, OP_MAX_SDWORD:
            for (int i = 0; i < 4; i++)
               if ((signed'(req.src[i*32 +: 32]) <
                    signed'(req.dst[i*32 +: 32])) ==
                   (req.op == OP_MIN_SDWORD))
                  alu_vec[i*32 +: 32] = req.src[i*32 +: 32];
         OP_ROUND_PACKED_SINGLE:
            for (int i = 0; i < 4; i++) begin
               rd = f_rint(s2d(req.src[i*32 +: 32]), rm);
               alu_vec[i*32 +: 32] = d2s(rd[63:0]);
               alu_inx = alu_inx | rd[64];
            end
         OP_ROUND_PACKED_DOUBLE:
            for (int i = 0; i < 2; i++) begin
               rd = f_rint(req.src[i*64 +: 64], rm);
               alu_vec[i*64 +: 64] = rd[63:0];
               alu_inx = alu_inx | rd[64];
            end
         OP_ROUND_SCALAR_SINGLE: begin
            rd = f_rint(s2d(req.src[31:0]), rm);
            alu_vec[31:0] = d2s(rd[63:0]);
            alu_inx = rd[64];
         end
         OP_ROUND_SCALAR_DOUBLE: begin
            rd = f_rint(req.src[63:0], rm);
            alu_vec[63:0] = rd[63:0];
            alu_inx = rd[64];
         end
         OP_EXTRACT_SINGLE: alu_gpr = {32'h0, req.src[req.imm[1:0]*32 +: 32]};
         OP_INSERT_SINGLE: begin
            ins = req.from_mem ? req.gpr[31:0]
                               : req.src[req.imm[7:6]*32 +: 32];
            alu_vec[req.imm[5:4]*32 +: 32] = ins;
            for (int i = 0; i < 4; i++)
               if (req.imm[i]) alu_vec[i*32 +: 32] = 32'h0;
         end
         OP_INSERT_BYTE: alu_vec[req.imm[3:0]*8 +: 8] = req.gpr[7:0];
         OP_INSERT_DWORD: alu_vec[req.imm[1:0]*32 +: 32] = req.gpr[31:0];
         OP_INSERT_QWORD: alu_vec[req.imm[0]*64 +: 64] = req.gpr;
         OP_EXTRACT_BYTE: alu_gpr = {56'h0, req.src[req.imm[3:0]*8 +: 8]};
         OP_EXTRACT_WORD: alu_gpr = {48'h0, req.src[req.imm[2:0]*16 +: 16]};
         OP_EXTRACT_DWORD: alu_gpr = {32'h0, req.src[req.imm[1:0]*32 +: 32]};
         OP_EXTRACT_QWORD: alu_gpr = req.src[req.imm[0]*64 +: 64];
         default: alu_vec = req.dst;
      endcase
      if (req.imm[IMM_NO_INEXACT]) alu_inx = 1'b0;
   end

   always_comb begin
      hit = 1'b0;
      hit_idx = 1'b0;
      for (int i = 0; i < SBUF_N; i++)
         if (svld_ff[i] && stag_ff[i] == req.addr[ADDR_W-1:LINE_LSB]) begin
            hit = 1'b1;
            hit_idx = 1'(i);
         end
   end

   assign req_ready = (state_ff == ST_IDLE);
   assign take = req_valid && req_ready;
   assign fill = (state_ff == ST_FETCH) && mem_rvalid;
   assign mem_req = (state_ff == ST_FETCH);
   assign mem_addr = {ld_addr_ff[ADDR_W-1:LINE_LSB], 6'h0};
   assign rsp = rsp_ff;
   assign rsp_valid = rsp_valid_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_rsp = rsp_ff;
      nxt_rsp_valid = 1'b0;
      nxt_ld_addr = ld_addr_ff;
      nxt_svld = svld_ff;
      nxt_victim = victim_ff;
      case (state_ff)
         ST_IDLE:
            if (take && req.op == OP_STREAMING_LOAD) begin
               if (hit) begin
                  nxt_rsp = '{vec: sbuf_ff[hit_idx][
                                 req.addr[LINE_LSB-1:ITEM_LSB]*VEC_W +: VEC_W],
                              gpr: 64'h0, inexact: 1'b0};
                  nxt_rsp_valid = 1'b1;
               end else begin
                  nxt_ld_addr = req.addr;
                  nxt_state = ST_FETCH;
               end
            end else if (take) begin
               nxt_rsp = '{vec: alu_vec, gpr: alu_gpr, inexact: alu_inx};
               nxt_rsp_valid = 1'b1;
            end
         // whole line held for later items
         ST_FETCH:
            if (mem_rvalid) begin
               nxt_rsp = '{vec: mem_rdata[
                              ld_addr_ff[LINE_LSB-1:ITEM_LSB]*VEC_W +: VEC_W],
                           gpr: 64'h0, inexact: 1'b0};
               nxt_rsp_valid = 1'b1;
               nxt_svld[victim_ff] = 1'b1;
               nxt_victim = ~victim_ff;
               nxt_state = ST_IDLE;
            end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= ST_IDLE;
         rsp_ff <= RSP_RST;
         rsp_valid_ff <= 1'b0;
         ld_addr_ff <= '0;
         svld_ff <= '0;
         victim_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         rsp_ff <= nxt_rsp;
         rsp_valid_ff <= nxt_rsp_valid;
         ld_addr_ff <= nxt_ld_addr;
         svld_ff <= nxt_svld;
         victim_ff <= nxt_victim;
      end
   end

   // line storage, valid bits guard it so no reset needed
   always_ff @(posedge clk) begin
      if (fill) begin
         sbuf_ff[victim_ff] <= mem_rdata;
         stag_ff[victim_ff] <= ld_addr_ff[ADDR_W-1:LINE_LSB];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   mul_low_lane_a: assert property (
      take && req.op == OP_MUL_DWORD_LOW |=> rsp_valid &&
      rsp.vec[31:0] == 32'($past(req.dst[31:0]) * $past(req.src[31:0])))
      else $error("low multiply lane 0 wrong");
   mul_wide_lane_a: assert property (
      take && req.op == OP_MUL_DWORD_WIDE |=> rsp.vec[127:64] ==
      64'(signed'({{32{$past(req.dst[95])}}, $past(req.dst[95:64])}) *
          signed'({{32{$past(req.src[95])}}, $past(req.src[95:64])})))
      else $error("wide multiply upper product wrong");
   dot_no_dest_a: assert property (
      take && req.op == OP_DOT_DOUBLE && req.imm[1:0] == 2'b00
      |=> rsp.vec == '0) else $error("dot product wrote unselected lane");
   blend_imm_a: assert property (
      take && req.op == OP_BLEND_SINGLE_IMM ##1 rsp_valid |->
      rsp.vec[63:32] == ($past(req.imm[1]) ? $past(req.src[63:32])
                                           : $past(req.dst[63:32])))
      else $error("immediate blend lane 1 wrong");
   min_sdword_a: assert property (
      take && req.op == OP_MIN_SDWORD |=> signed'(rsp.vec[31:0]) <=
      signed'($past(req.dst[31:0])) && signed'(rsp.vec[31:0]) <=
      signed'($past(req.src[31:0]))) else $error("signed dword min wrong");
   round_scalar_a: assert property (
      take && req.op == OP_ROUND_SCALAR_DOUBLE |=>
      rsp.vec[127:64] == $past(req.dst[127:64]))
      else $error("scalar round changed upper element");
   inexact_off_a: assert property (
      take && req.imm[IMM_NO_INEXACT] && req.op != OP_STREAMING_LOAD
      |=> !rsp.inexact) else $error("suppressed inexact reported");
   insert_zero_a: assert property (
      take && req.op == OP_INSERT_SINGLE && req.imm[2] |=>
      rsp.vec[95:64] == 32'h0) else $error("insert zero mask ignored");
   extract_dword_a: assert property (
      take && req.op == OP_EXTRACT_DWORD && req.imm[1:0] == 2'd3 |=>
      rsp.gpr == {32'h0, $past(req.src[127:96])})
      else $error("dword extraction wrong");
   stream_hit_a: assert property (
      take && req.op == OP_STREAMING_LOAD && hit |=> rsp_valid && !mem_req)
      else $error("buffered line not served locally");
   stream_fill_a: assert property (
      mem_req && mem_rvalid |=> rsp_valid && req_ready && svld_ff != '0)
      else $error("line fill did not answer");

   hit_cov_c: cover property (take && req.op == OP_STREAMING_LOAD && hit);
   miss_cov_c: cover property (mem_req ##[1:20] mem_rvalid);
   dot_cov_c: cover property (take && req.op == OP_DOT_SINGLE);
   rnd_cov_c: cover property (take && req.op == OP_ROUND_PACKED_DOUBLE ##1
                              rsp.inexact);
endmodule // pse_datapath

/* design/pse_pkg.sv */
package pse_pkg;
   localparam int VEC_W = 128;
   localparam int ADDR_W = 32;
   localparam int LINE_W = 512;
   localparam int SBUF_N = 2;
   localparam int LINE_LSB = 6;
   localparam int ITEM_LSB = 4;
   localparam logic [10:0] DBL_BIAS = 11'h03ff;
   localparam logic [10:0] SGL_REBIAS = 11'h0380;
   localparam logic [10:0] DBL_INT_EXP = 11'h0433;
   localparam logic [10:0] DBL_MAX_EXP = 11'h07ff;
   localparam logic [10:0] SGL_MAX_IN_DBL = 11'h047f;
   localparam int IMM_RC_SRC = 2;
   localparam int IMM_NO_INEXACT = 3;
   localparam logic [1:0] RM_NEAR = 2'h0;
   localparam logic [1:0] RM_DOWN = 2'h1;
   localparam logic [1:0] RM_UP = 2'h2;
   localparam logic [1:0] RM_TRUNC = 2'h3;

   typedef enum logic [4:0] {
      OP_MUL_DWORD_LOW, OP_MUL_DWORD_WIDE, OP_DOT_DOUBLE, OP_DOT_SINGLE,
      OP_STREAMING_LOAD, OP_BLEND_DOUBLE_IMM, OP_BLEND_SINGLE_IMM,
      OP_BLEND_WORD_IMM, OP_BLEND_DOUBLE_VAR, OP_BLEND_SINGLE_VAR,
      OP_BLEND_BYTE_VAR, OP_MIN_UWORD, OP_MIN_UDWORD, OP_MIN_SBYTE,
      OP_MIN_SDWORD, OP_MAX_UWORD, OP_MAX_UDWORD, OP_MAX_SBYTE,
      OP_MAX_SDWORD, OP_ROUND_PACKED_SINGLE, OP_ROUND_PACKED_DOUBLE,
      OP_ROUND_SCALAR_SINGLE, OP_ROUND_SCALAR_DOUBLE, OP_EXTRACT_SINGLE,
      OP_INSERT_SINGLE, OP_INSERT_BYTE, OP_INSERT_DWORD, OP_INSERT_QWORD,
      OP_EXTRACT_BYTE, OP_EXTRACT_WORD, OP_EXTRACT_DWORD, OP_EXTRACT_QWORD
   } pse_op_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01
   } pse_state_t;

   typedef struct packed {
      pse_op_t            op;
      logic [VEC_W-1:0]   dst;
      logic [VEC_W-1:0]   src;
      logic [7:0]         imm;
      logic [VEC_W-1:0]   mask;
      logic [63:0]        gpr;
      logic               from_mem;
      logic [ADDR_W-1:0]  addr;
   } pse_req_t;

   typedef struct packed {
      logic [VEC_W-1:0]   vec;
      logic [63:0]        gpr;
      logic               inexact;
   } pse_rsp_t;

   localparam pse_rsp_t RSP_RST = '0;
endpackage

/* sim/pse_mem_model.sv */
module pse_mem_model import pse_pkg::*; (
   input  wire logic              clk,        // core clock
   input  wire logic              nrst,       // async reset, active low
   input  wire logic              mem_req,    // line fetch request
   input  wire logic [ADDR_W-1:0] mem_addr,   // aligned line address
   output      logic              mem_rvalid, // line returned, one cycle
   output      logic [LINE_W-1:0] mem_rdata   // whole line
);
   timeunit 1ns;
   timeprecision 1ps;
   int   wait_cnt;
   logic slow;

   // answers alternately at once and after a stall
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wait_cnt <= 0;
         slow <= 1'b0;
         mem_rvalid <= 1'b0;
         mem_rdata <= '0;
      end else if (mem_req && !mem_rvalid && wait_cnt >= (slow ? 5 : 0)) begin
         mem_rvalid <= 1'b1;
         for (int k = 0; k < 4; k++)
            mem_rdata[k*128 +: 128] <= {4{mem_addr + 32'(k * 16)}};
         slow <= !slow;
         wait_cnt <= 0;
      end else begin
         mem_rvalid <= 1'b0;
         // no stale line between answers
         mem_rdata <= ~mem_rdata;
         wait_cnt <= mem_req ? wait_cnt + 1 : 0;
      end
   end
endmodule // pse_mem_model

/* sim/test_packed_simd_ext_ops.sv */
module test_packed_simd_ext_ops;
   import pse_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      pse_rsp_t   r;
      logic [2:0] care;
   } pse_exp_t;
   logic              clk, nrst, req_valid, req_ready, rsp_valid;
   logic              mem_req, mem_rvalid, ix;
   logic [1:0]        rc_mode;
   logic [ADDR_W-1:0] mem_addr;
   logic [LINE_W-1:0] mem_rdata;
   logic [VEC_W-1:0]  e;
   logic [63:0]       g;
   logic [15:0]       sel;
   pse_req_t          req;
   pse_rsp_t          rsp;
   pse_exp_t          x;
   pse_exp_t          exp_q[$];
   int                num_errors = 0, total_checks = 0, cycles = 0;
   int                fetches = 0, w, l;
   int                bw[6] = '{64, 32, 16, 64, 32, 8};
   int                xw[5] = '{8, 16, 32, 64, 32};
   int                mw[4] = '{16, 32, 8, 32};
   logic [31:0]       la[5] = '{32'h0000_1230, 32'h0000_1210,
                                32'h0000_1240, 32'h0000_1270, 32'h0000_1200};

   pse_datapath dut (.clk(clk), .nrst(nrst), .req(req),
      .req_valid(req_valid), .req_ready(req_ready), .rc_mode(rc_mode),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata), .rsp(rsp), .rsp_valid(rsp_valid));
   pse_mem_model mem (.clk(clk), .nrst(nrst), .mem_req(mem_req),
      .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic complete_run();
      $display("errors %0d checks %0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (mem_req === 1'b1 && mem_rvalid === 1'b1) fetches <= fetches + 1;
      if (cycles == 3000) begin
         num_errors = num_errors + 1;
         complete_run();
      end
   end

   task automatic bad(input string m);
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic cmp_vec(input logic [VEC_W-1:0] a, b);
      total_checks++;
      if (a !== b) bad($sformatf("vector %h, wanted %h", a, b));
   endtask
   task automatic cmp_gpr(input logic [63:0] a, b);
      total_checks++;
      if (a !== b) bad($sformatf("scalar %h, wanted %h", a, b));
   endtask
   task automatic cmp_bit(input logic a, b);
      total_checks++;
      if (a !== b) bad($sformatf("flag %b, wanted %b", a, b));
   endtask

   always @(negedge clk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            bad("result without request");
         end else begin
            x = exp_q.pop_front();
            if (x.care[0]) cmp_vec(rsp.vec, x.r.vec);
            if (x.care[1]) cmp_gpr(rsp.gpr, x.r.gpr);
            if (x.care[2]) cmp_bit(rsp.inexact, x.r.inexact);
         end
      end
   end

   task automatic go(input logic [2:0] c);
      exp_q.push_back('{r: '{vec: e, gpr: g, inexact: ix}, care: c});
      req_valid = 1'b1;
      while (req_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
   endtask

   task automatic rnd();
      req.dst = {$urandom, $urandom, $urandom, $urandom};
      req.src = {$urandom, $urandom, $urandom, $urandom};
      req.mask = {$urandom, $urandom, $urandom, $urandom};
      req.gpr = {$urandom, $urandom};
      req.imm = 8'($urandom);
   endtask

   function automatic logic [63:0] sm(input logic [31:0] p, q);
      longint a, b;
      a = $signed(p);
      b = $signed(q);
      return a * b;
   endfunction

   function automatic logic [VEC_W-1:0] bl(input logic [15:0] s, input int n);
      bl = req.dst;
      for (int b = 0; b < VEC_W; b++)
         if (s[b / n]) bl[b] = req.src[b];
   endfunction

   function automatic logic [VEC_W-1:0] mm(input int n, input bit sg, mx);
      longint a, b;
      mm = req.dst;
      for (int k = 0; k < VEC_W / n; k++) begin
         a = 0;
         b = 0;
         for (int i = 0; i < n; i++) begin
            a[i] = req.dst[k*n + i];
            b[i] = req.src[k*n + i];
         end
         if (sg) begin
            a = (a <<< (64 - n)) >>> (64 - n);
            b = (b <<< (64 - n)) >>> (64 - n);
         end
         for (int i = 0; i < n; i++)
            mm[k*n + i] = ((a < b) == mx) ? b[i] : a[i];
      end
   endfunction

   initial begin
      nrst = 1'b0;
      req_valid = 1'b0;
      req = '0;
      ix = 1'b0;
      g = '0;
      rc_mode = RM_TRUNC;
      void'($urandom(32));
      repeat (6) @(posedge clk);
      #1 nrst = 1'b1;
      for (int j = 0; j < 4; j++) begin
         rnd();
         if (j == 0) begin
            req.dst = {4{32'h8000_0000}};
            req.src = {4{32'hffff_ffff}};
         end
         req.op = OP_MUL_DWORD_LOW;
         for (int k = 0; k < 4; k++)
            e[k*32 +: 32] = 32'(sm(req.dst[k*32 +: 32], req.src[k*32 +: 32]));
         go(3'b001);
         req.op = OP_MUL_DWORD_WIDE;
         e = {sm(req.dst[95:64], req.src[95:64]),
              sm(req.dst[31:0], req.src[31:0])};
         go(3'b001);
      end
      for (int j = 0; j < 8; j++) begin
         rnd();
         req.op = pse_op_t'(OP_MIN_UWORD + j);
         e = mm(mw[j % 4], j % 4 > 1, j > 3);
         go(3'b001);
      end
      for (int j = 0; j < 6; j++) begin
         rnd();
         req.op = pse_op_t'(OP_BLEND_DOUBLE_IMM + j);
         sel = {8'h00, req.imm};
         for (int k = 0; k < VEC_W / bw[j]; k++)
            if (j > 2) sel[k] = req.mask[k*bw[j] + bw[j] - 1];
         e = bl(sel, bw[j]);
         go(3'b001);
      end
      for (int j = 0; j < 3; j++) begin
         rnd();
         req.op = pse_op_t'(OP_INSERT_BYTE + j);
         w = j == 0 ? 8 : 32 * j;
         l = req.imm % (VEC_W / w);
         e = req.dst;
         for (int b = 0; b < w; b++)
            e[l*w + b] = req.gpr[b];
         go(3'b001);
      end
      for (int j = 0; j < 5; j++) begin
         rnd();
         req.src = req.dst;
         if (j == 2) req.imm[1:0] = 2'h3;
         req.op = j < 4 ? pse_op_t'(OP_EXTRACT_BYTE + j) : OP_EXTRACT_SINGLE;
         l = req.imm % (VEC_W / xw[j]);
         g = '0;
         for (int b = 0; b < xw[j]; b++)
            g[b] = req.dst[l*xw[j] + b];
         go(3'b010);
      end
      for (int j = 0; j < 2; j++) begin
         rnd();
         req.op = OP_INSERT_SINGLE;
         req.from_mem = j[0];
         req.imm[2] = j[0];
         e = req.dst;
         e[req.imm[5:4]*32 +: 32] = j ? req.gpr[31:0]
                                      : req.src[req.imm[7:6]*32 +: 32];
         for (int k = 0; k < 4; k++)
            if (req.imm[k]) e[k*32 +: 32] = '0;
         go(3'b001);
      end
      rc_mode = RM_UP;
      req.op = OP_ROUND_PACKED_DOUBLE;
      req.src = {64'hbff8_0000_0000_0000, 64'h4004_0000_0000_0000};
      for (int m = 0; m < 5; m++) begin
         req.imm = m < 4 ? 8'(m) : 8'h0c;
         l = m < 4 ? m : 2;
         e = {l > 1 ? 64'hbff0_0000_0000_0000 : 64'hc000_0000_0000_0000,
              l == 2 ? 64'h4008_0000_0000_0000 : 64'h4000_0000_0000_0000};
         ix = m < 4;
         go(3'b101);
      end
      req.op = OP_ROUND_SCALAR_SINGLE;
      req.imm = 8'h02;
      req.src[31:0] = 32'h4020_0000;
      e = {req.dst[127:32], 32'h4040_0000};
      ix = 1'b1;
      go(3'b101);
      req.op = OP_ROUND_SCALAR_DOUBLE;
      req.src[63:0] = 64'hbff8_0000_0000_0000;
      e = {req.dst[127:64], 64'hbff0_0000_0000_0000};
      go(3'b101);
      req.op = OP_ROUND_PACKED_SINGLE;
      req.src = {4{32'h3fc0_0000}};
      e = {4{32'h4000_0000}};
      go(3'b101);
      req.op = OP_DOT_DOUBLE;
      req.imm = 8'h33;
      req.dst = {64'h4000_0000_0000_0000, 64'h3ff0_0000_0000_0000};
      req.src = {64'h4010_0000_0000_0000, 64'h4008_0000_0000_0000};
      e = {2{64'h4026_0000_0000_0000}};
      go(3'b001);
      req.imm = 8'h10;
      e = '0;
      go(3'b001);
      req.op = OP_DOT_SINGLE;
      req.imm = 8'hff;
      req.dst = {32'h4080_0000, 32'h4040_0000, 32'h4000_0000, 32'h3f80_0000};
      req.src = {4{32'h3f80_0000}};
      e = {4{32'h4120_0000}};
      go(3'b001);
      req.op = OP_STREAMING_LOAD;
      for (int j = 0; j < 5; j++) begin
         req.addr = la[j];
         e = {4{la[j]}};
         go(3'b001);
         if (j == 0 || j == 2) begin
            cmp_bit(mem_req, 1'b1);
            cmp_gpr(64'(mem_addr), 64'(la[j] & 32'hffff_ffc0));
         end
      end
      req_valid = 1'b0;
      while (exp_q.size() != 0) @(posedge clk);
      @(posedge clk);
      cmp_gpr(64'(fetches), 64'h0000_0000_0000_0002);
      complete_run();
   end
endmodule // test_packed_simd_ext_ops
